// >>> logic/fadc_defs.svh
// register map, reset values and timing counts of the flash converter control
`ifndef FADC_DEFS_SVH
`define FADC_DEFS_SVH

`define FADC_ADDR_W 8
`define FADC_OFS_CTRL 8'h00
`define FADC_OFS_STATUS 8'h04
`define FADC_OFS_COUNT 8'h08

`define FADC_CTRL_DLY_LSB 0
`define FADC_CTRL_DLY_W 4

`define FADC_ST_CODE_LSB 0
`define FADC_ST_OVF_BIT 6
`define FADC_ST_MODE_SEL_BIT 8
`define FADC_ST_PHASE_BIT 9
`define FADC_ST_RESERVED_BIT 10
`define FADC_ST_PENDING_BIT 11

`define FADC_CLK_PERIOD_NS 10
`define FADC_APERTURE_DELAY_NS 25
`define FADC_CLK_DELAY_NS 10
`define FADC_ACQ_DELAY_CYC \
    ((`FADC_APERTURE_DELAY_NS + `FADC_CLK_DELAY_NS + `FADC_CLK_PERIOD_NS - 1) / `FADC_CLK_PERIOD_NS)

`define FADC_DE_N_DEFAULT 1'h0
`define FADC_OE_M_DEFAULT 1'h1

`endif

// >>> logic/fadc_pkg.sv
// types shared by the flash converter control modules
package fadc_pkg;
    typedef logic [5:0] fadc_code_t;
    typedef logic [63:0] fadc_therm_t;
    typedef enum logic [3:0] {
        FADC_PIPE_SLO = 4'h1,
        FADC_PIPE_SHI = 4'h2,
        FADC_ONE_SHOT = 4'h4,
        FADC_RESERVED = 4'h8
    } fadc_mode_e;
endpackage : fadc_pkg

// >>> logic/fadc_therm_enc.sv
// thermometer to binary encoder for the 64 comparator outputs
`timescale 1ns/100ps
module fadc_therm_enc (
    input wire fadc_pkg::fadc_therm_t therm,
    output fadc_pkg::fadc_code_t code,
    output logic overflow
);
    // counting ones tolerates single bubbles in the thermometer
    function automatic fadc_pkg::fadc_code_t fadc_count_ones(input logic [62:0] t);
        logic [6:0] n;
        n = 7'h00;
        for (int i = 0; i < 63; i++) begin
            n = n + {6'h00, t[i]};
        end
        return n[5:0];
    endfunction : fadc_count_ones

    assign code = fadc_count_ones(therm[62:0]);
    assign overflow = therm[63];
endmodule : fadc_therm_enc

// >>> logic/fadc_ctrl.sv
// timing and output control of a 6-bit flash converter, with APB status access
//
// Summary of operation
// R1: two pipelined modes and one-shot, chosen only by mode_select and sample_phase pins.
// R2: mode_select high converts on every clock cycle without any start command.
// R3: pipelined, sample_phase low: sample while clock low, balance while high.
// R4: pipelined, sample_phase high: sample while clock high, balance while low.
// R5: acquisition window is the sample phase delayed by clock plus aperture delay.
// R6: 64 comparator outputs encoded to binary, plus a separate overflow flag.
// R7: 6-bit straight binary result, bit 5 most significant, bit 0 least.
// R8: the system clocks conversions between 1 kHz and 6.0 MHz.
// R9: undriven data_enable_n reads low, undriven output_enable_master reads high.
// R10: enables act asynchronously; master low floats all; data also needs data_enable_n low.
// R11: pipelined conversion takes 1.5 cycles; results move out as next sample is taken.
// R12: both pins low gives one-shot, done in two edges (one clock pulse).
// R13: the system never holds mode_select low with sample_phase high.
// R14: code and overflow update together at sample-phase end, held until the next; one-shot updates them at the falling edge instead.
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "fadc_defs.svh"
module fadc_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic conv_clk,
    input wire logic mode_select,
    input wire logic sample_phase,
    input wire fadc_pkg::fadc_therm_t comparator_therm,
    input wire logic data_enable_n,
    input wire logic data_enable_n_undriven,
    input wire logic output_enable_master,
    input wire logic output_enable_master_undriven,
    output logic sample_active,
    output logic balance_active,
    output logic acq_window,
    output logic [5:0] code_out,
    output logic [5:0] code_oe_n,
    output logic overflow_flag,
    output logic overflow_oe_n
);
    logic clk_q, clk_p_q;
    logic rise, fall, end_edge;
    fadc_pkg::fadc_mode_e mode_q;
    fadc_pkg::fadc_code_t enc_code, latch_code_q, code_q;
    logic enc_ovf, latch_ovf_q, ovf_q, pend_q;
    logic sample_q, balance_q, acq_q;
    logic [15:0] dly_line_q;
    logic [`FADC_CTRL_DLY_W-1:0] dly_q;
    logic [31:0] count_q, prdata_q;
    logic pready_q, pslverr_q;
    logic de_n_res, oe_m_res;
    logic is_pipe;

    ////////////////////////////////////////////////////////////////////////
    // clock edges and mode decode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_q <= 1'h0;
            clk_p_q <= 1'h0;
        end else begin
            clk_q <= conv_clk;
            clk_p_q <= clk_q;
        end
    end

    assign rise = clk_q & ~clk_p_q;
    assign fall = ~clk_q & clk_p_q;

    // pins are static, so sampling them every cycle is enough
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= fadc_pkg::FADC_RESERVED;
        end else begin
            case ({mode_select, sample_phase}) // R1
                2'h3: mode_q <= fadc_pkg::FADC_PIPE_SHI;
                2'h2: mode_q <= fadc_pkg::FADC_PIPE_SLO;
                2'h0: mode_q <= fadc_pkg::FADC_ONE_SHOT; // R12
                default: mode_q <= fadc_pkg::FADC_RESERVED;
            endcase
        end
    end

    assign is_pipe = (mode_q == fadc_pkg::FADC_PIPE_SLO) || (mode_q == fadc_pkg::FADC_PIPE_SHI);
    assign end_edge = (mode_q == fadc_pkg::FADC_PIPE_SHI) ? fall : rise;

    ////////////////////////////////////////////////////////////////////////
    // sample and balance phases, acquisition window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_q <= 1'h0;
            balance_q <= 1'h0;
        end else begin
            case (mode_q)
                fadc_pkg::FADC_PIPE_SLO: begin
                    sample_q <= ~clk_q; // R3
                    balance_q <= clk_q; // R3
                end
                fadc_pkg::FADC_PIPE_SHI: begin
                    sample_q <= clk_q; // R4
                    balance_q <= ~clk_q; // R4
                end
                fadc_pkg::FADC_ONE_SHOT: begin
                    sample_q <= ~clk_q;
                    balance_q <= clk_q;
                end
                default: begin
                    sample_q <= 1'h0;
                    balance_q <= 1'h0;
                end
            endcase
        end
    end

    // delay of zero still costs one register stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly_line_q <= 16'h0000;
            acq_q <= 1'h0;
        end else begin
            dly_line_q <= {dly_line_q[14:0], sample_q}; // R5
            acq_q <= (dly_q == 4'h0) ? sample_q : dly_line_q[dly_q - 4'h1]; // R5
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // comparator latch and output register
    fadc_therm_enc u_enc (
        .therm(comparator_therm),
        .code(enc_code),
        .overflow(enc_ovf)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_code_q <= 6'h00;
            latch_ovf_q <= 1'h0;
            code_q <= 6'h00;
            ovf_q <= 1'h0;
            pend_q <= 1'h0;
        end else if (is_pipe) begin
            pend_q <= 1'h0;
            if (end_edge) begin
                latch_code_q <= enc_code; // R6
                latch_ovf_q <= enc_ovf; // R6
                code_q <= latch_code_q; // R11 R14 R2
                ovf_q <= latch_ovf_q; // R14
            end
        end else if (mode_q == fadc_pkg::FADC_ONE_SHOT) begin
            if (rise) begin
                latch_code_q <= enc_code;
                latch_ovf_q <= enc_ovf;
                pend_q <= 1'h1;
            end else if (fall && pend_q) begin
                code_q <= latch_code_q; // R12
                ovf_q <= latch_ovf_q;
                pend_q <= 1'h0;
            end
        end else begin
            pend_q <= 1'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= 32'h00000000;
        end else if ((is_pipe && end_edge) || (mode_q == fadc_pkg::FADC_ONE_SHOT && fall && pend_q)) begin
            count_q <= count_q + 32'h00000001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output buffers: enables stay combinational so they act asynchronously
    assign de_n_res = data_enable_n_undriven ? `FADC_DE_N_DEFAULT : data_enable_n; // R9
    assign oe_m_res = output_enable_master_undriven ? `FADC_OE_M_DEFAULT : output_enable_master; // R9
    assign overflow_oe_n = ~oe_m_res; // R10
    assign code_oe_n = {6{~(oe_m_res & ~de_n_res)}}; // R10
    assign code_out = code_q; // R7
    assign overflow_flag = ovf_q;
    assign sample_active = sample_q;
    assign balance_active = balance_q;
    assign acq_window = acq_q;

    ////////////////////////////////////////////////////////////////////////
    // APB slave, one wait state per access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'h0;
            pslverr_q <= 1'h0;
            prdata_q <= 32'h00000000;
            dly_q <= 4'(`FADC_ACQ_DELAY_CYC);
        end else begin
            pready_q <= psel & penable & ~pready_q;
            pslverr_q <= 1'h0;
            prdata_q <= 32'h00000000;
            if (psel && penable && !pready_q) begin
                case (paddr)
                    `FADC_OFS_CTRL: begin
                        if (!pwrite) begin
                            prdata_q <= {28'h0000000, dly_q};
                        end
                    end
                    `FADC_OFS_STATUS: begin
                        prdata_q[`FADC_ST_CODE_LSB +: 6] <= code_q;
                        prdata_q[`FADC_ST_OVF_BIT] <= ovf_q;
                        prdata_q[`FADC_ST_MODE_SEL_BIT] <= mode_select;
                        prdata_q[`FADC_ST_PHASE_BIT] <= sample_phase;
                        prdata_q[`FADC_ST_RESERVED_BIT] <= (mode_q == fadc_pkg::FADC_RESERVED);
                        prdata_q[`FADC_ST_PENDING_BIT] <= pend_q;
                    end
                    `FADC_OFS_COUNT: prdata_q <= count_q;
                    default: pslverr_q <= 1'h1;
                endcase
            end
            // write lands on the completing edge, the one at which the master sees pready
            if (psel && penable && pready_q && pwrite && (paddr == `FADC_OFS_CTRL)) begin
                dly_q <= pwdata[`FADC_CTRL_DLY_LSB +: `FADC_CTRL_DLY_W];
            end
        end
    end

    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign prdata = prdata_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_pipe_out_move: assert property (@(posedge pclk) disable iff (!presetn) // R14
        (is_pipe && end_edge) |=> (code_q == $past(latch_code_q) && ovf_q == $past(latch_ovf_q)))
        else $error("pipelined output did not take the latched result");
    a_pipe_latch: assert property (@(posedge pclk) disable iff (!presetn) // R11
        (is_pipe && end_edge) |=> (latch_code_q == $past(enc_code) && latch_ovf_q == $past(enc_ovf)))
        else $error("comparator result not latched at sample end");
    a_pipe_hold: assert property (@(posedge pclk) disable iff (!presetn) // R14
        (is_pipe && !end_edge && $stable(mode_q)) |=> $stable(code_q))
        else $error("output code changed between updates");
    a_one_shot_out: assert property (@(posedge pclk) disable iff (!presetn) // R12
        (mode_q == fadc_pkg::FADC_ONE_SHOT && fall && pend_q)
        |=> (code_q == $past(latch_code_q) && ovf_q == $past(latch_ovf_q)))
        else $error("one-shot result not delivered on falling edge");
    a_one_shot_latch: assert property (@(posedge pclk) disable iff (!presetn) // R12
        (mode_q == fadc_pkg::FADC_ONE_SHOT && rise)
        |=> (pend_q && latch_code_q == $past(enc_code) && latch_ovf_q == $past(enc_ovf)))
        else $error("one-shot rising edge did not latch the comparators");
    a_phase_lo: assert property (@(posedge pclk) disable iff (!presetn) // R3
        (mode_q == fadc_pkg::FADC_PIPE_SLO) ##1 (mode_q == fadc_pkg::FADC_PIPE_SLO)
        |-> (sample_q == ~$past(clk_q) && balance_q == $past(clk_q)))
        else $error("sampling not in clock low phase");
    a_phase_hi: assert property (@(posedge pclk) disable iff (!presetn) // R4
        (mode_q == fadc_pkg::FADC_PIPE_SHI) ##1 (mode_q == fadc_pkg::FADC_PIPE_SHI)
        |-> (sample_q == $past(clk_q) && balance_q == ~$past(clk_q)))
        else $error("sampling not in clock high phase");
    a_acq_delay: assert property (@(posedge pclk) disable iff (!presetn) // R5
        ($rose(sample_q) && dly_q == 4'h4) ##0 (dly_q == 4'h4)[*5] |=> $rose(acq_q))
        else $error("acquisition window not delayed by delay plus one cycles");
    a_master_float: assert property (@(posedge pclk) disable iff (!presetn) // R10
        !oe_m_res |-> (overflow_oe_n && code_oe_n == 6'h3F))
        else $error("outputs driven with master enable low");
    a_data_enable: assert property (@(posedge pclk) disable iff (!presetn) // R10
        oe_m_res |-> (!overflow_oe_n && (code_oe_n == (de_n_res ? 6'h3F : 6'h00))))
        else $error("data enable decode wrong");
    a_enable_default: assert property (@(posedge pclk) disable iff (!presetn) // R9
        (data_enable_n_undriven && output_enable_master_undriven) |-> (code_oe_n == 6'h00 && !overflow_oe_n))
        else $error("undriven enables did not enable outputs");
    a_reserved_idle: assert property (@(posedge pclk) disable iff (!presetn) // R1
        (mode_q == fadc_pkg::FADC_RESERVED) |=> ($stable(code_q) && !sample_q))
        else $error("activity in reserved mode");
endmodule : fadc_ctrl

// >>> verif/fadc_sys_model.sv
// system-side model: conversion clock source and output code latch
`timescale 1ns/100ps
module fadc_sys_model #(
    parameter int HALF = 9
) (
    input wire logic pclk,
    input wire logic run,
    input wire logic [5:0] code_out,
    input wire logic overflow_flag,
    output logic conv_clk,
    output logic [5:0] held_code,
    output logic held_ovf
);
    int cnt = 0;
    // nine pclk per half keeps the rate at 5.56 MHz, inside the allowed band
    always @(posedge pclk) begin
        if (!run) begin
            cnt <= 0;
            conv_clk <= 1'h0;
        end else begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1) begin
                conv_clk <= ~conv_clk;
            end
        end
    end
    // latch on the falling edge, half a clock away from the output update only in the pipelined mode with sample_phase low
    always @(negedge conv_clk) begin
        held_code <= code_out;
        held_ovf <= overflow_flag;
    end
endmodule : fadc_sys_model

// >>> verif/flash_adc_timing_and_output_control_tb.sv
// self-checking bench of the flash converter timing and output control
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin mismatches++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end
module flash_adc_timing_and_output_control_tb;
    localparam int HALF = 9;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd, c0;
    logic pready, pslverr, er, conv_clk, sample_active, balance_active, acq_window;
    logic run = 1'h0;
    logic mode_select = 1'h1;
    logic sample_phase = 1'h0;
    fadc_pkg::fadc_therm_t comparator_therm = 64'h0;
    logic data_enable_n = 1'h0;
    logic data_enable_n_undriven = 1'h0;
    logic output_enable_master = 1'h1;
    logic output_enable_master_undriven = 1'h0;
    logic overflow_flag, overflow_oe_n, held_ovf, o;
    logic [5:0] code_out, code_oe_n, held_code, n;
    logic [1:0] m;
    logic [5:0] mtab = 6'h2C;
    integer seed;
    int mismatches = 0;
    int total_checks = 0;
    int k;

    always #5 pclk = ~pclk;

    fadc_ctrl fadc_ctrl_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .conv_clk, .mode_select, .sample_phase, .comparator_therm, .data_enable_n,
        .data_enable_n_undriven, .output_enable_master, .output_enable_master_undriven, .sample_active,
        .balance_active, .acq_window, .code_out, .code_oe_n, .overflow_flag, .overflow_oe_n);
    fadc_sys_model #(.HALF(HALF)) fadc_sys_model_i (.pclk, .run, .code_out, .overflow_flag, .conv_clk,
        .held_code, .held_ovf);

    function automatic fadc_pkg::fadc_therm_t therm_of(input logic [5:0] c, input logic ov);
        fadc_pkg::fadc_therm_t t;
        t = (64'h1 << c) - 64'h1;
        t[63] = ov;
        return t;
    endfunction : therm_of

    // one transfer; read data and error are taken at the edge that sees pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int w;
        w = 0;
        @(posedge pclk);
        psel <= 1'h1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            w++;
        end while (pready !== 1'h1 && w < 20);
        if (pready !== 1'h1) begin
            mismatches++;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic settle(input int cyc);
        repeat (cyc) @(posedge pclk);
        #1;
    endtask : settle

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        seed = 32'he6a0bf70;
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        run <= 1'h1;
        apb(1'h0, 8'h00, 32'h00000000);
        `CHK("ctrl reset", 32'h00000004, rd)
        apb(1'h0, 8'h0C, 32'h00000000);
        `CHK("unmapped error", 1'h1, er)
        apb(1'h1, 8'h00, 32'h00000003);
        @(posedge sample_active);
        k = 0;
        while (acq_window !== 1'h1 && k < 40) begin
            settle(1);
            k++;
        end
        `CHK("acq lag", 4, k)
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            data_enable_n <= i[0];
            output_enable_master <= i[1];
            #1;
            `CHK("data oe_n", (i == 2) ? 6'h00 : 6'h3F, code_oe_n)
            `CHK("ovf oe_n", ~i[1], overflow_oe_n)
        end
        @(posedge pclk);
        data_enable_n <= 1'h1;
        output_enable_master <= 1'h0;
        data_enable_n_undriven <= 1'h1;
        output_enable_master_undriven <= 1'h1;
        settle(1);
        `CHK("floating data oe_n", 6'h00, code_oe_n)
        `CHK("floating ovf oe_n", 1'h0, overflow_oe_n)
        $display("test enables done");
        for (int i = 0; i < 3; i++) begin
            m = mtab[5 - 2 * i -: 2];
            n = 6'($unsigned($random(seed)) % 64);
            o = 1'($random(seed));
            @(posedge pclk);
            mode_select <= m[1];
            sample_phase <= m[0];
            comparator_therm <= therm_of(n, o);
            settle(6 * HALF);
            `CHK("code", n, code_out)
            `CHK("overflow", o, overflow_flag)
            `CHK("held code", n, held_code)
            `CHK("held overflow", o, held_ovf)
            apb(1'h0, 8'h04, 32'h00000000);
            `CHK("mode pins", {m[0], m[1]}, rd[9:8])
            `CHK("status code", n, rd[5:0])
            `CHK("status overflow", o, rd[6])
            apb(1'h0, 8'h08, 32'h00000000);
            c0 = rd;
            repeat (20 * HALF - 4) @(posedge pclk);
            apb(1'h0, 8'h08, 32'h00000000);
            `CHK("count step", 32'h0000000A, rd - c0)
            if (m[1]) begin
                @(negedge conv_clk);
                settle(4);
                `CHK("sampling", ~m[0], sample_active)
                `CHK("balancing", m[0], balance_active)
            end
            if (i == 0) begin
                @(posedge conv_clk);
                repeat (6) @(posedge pclk);
                comparator_therm <= therm_of(~n, o);
                @(posedge conv_clk);
                settle(5);
                `CHK("one stage", n, code_out)
                @(posedge conv_clk);
                settle(5);
                `CHK("two stages", ~n, code_out)
            end
            $display("test mode %b done", m);
        end
        tally_and_finish();
    end
endmodule : flash_adc_timing_and_output_control_tb
